// [logic/bcs_map.svh]
// Purpose: Timing counts and routing codes for the bypass contactor sequencer.
// Assumes: 50 MHz reference clock, 20 ns period.
// Notes: Times are in milliseconds; cycle counts derive from them.
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
`define BCS_CLK_HZ 50000000
`define BCS_INTERLOCK_MS 1000
`define BCS_START_WAIT_MS 500
`define BCS_INTERLOCK_CYC ((`BCS_CLK_HZ / 1000) * `BCS_INTERLOCK_MS)
`define BCS_START_WAIT_CYC ((`BCS_CLK_HZ / 1000) * `BCS_START_WAIT_MS)
`define BCS_FN_THERMAL 8'h07
`define BCS_FN_INPUT_MC 8'h11
`define BCS_FN_BYPASS_MC 8'h12
`define BCS_FN_OUTPUT_MC 8'h13
`endif

// [logic/bcs_pkg.sv]
// Purpose: Types shared by the sequencer files.
// Assumes: Nothing beyond the map header.
// Notes: One-hot sequencing states.
`default_nettype none
package bcs_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_GAP_TO_INV = 5'h02,
        ST_INV_WAIT = 5'h04,
        ST_INV_RUN = 5'h08,
        ST_GAP_TO_BYP = 5'h10
    } bcs_state_t;
endpackage
`default_nettype wire

// [logic/bcs_sequencer.sv]
// Purpose: Drives input, bypass and output contactors for bypass switchover.
// Assumes: Single 50 MHz clock, synchronous active-high reset.
// Notes: Delay counts are parameters so a bench can shorten them.
// Operation
// RULE1 - Input contactor on; opens on fault until reset.
// RULE2 - Bypass on in bypass, fault per select, thermal.
// RULE3 - Output contactor only on in inverter operation; the code holds it at its last state while permit is low or init is high.
// RULE4 - No operation without permit; bypass off then.
// RULE5 - Select high inverter, low bypass, permit only.
// RULE6 - Run commands honored with permit and inverter.
// RULE7 - Thermal abnormal opens all three contactors.
// RULE8 - Hold on no change; init forces bypass off.
// RULE9 - Controls routed to terminals by codes 17-19.
// RULE10 - Interlock delay between bypass and output closing.
// RULE11 - Start delay after output contactor closes.
// RULE12 - Fault coasts, or switches to bypass if selected.
// RULE13 - Inputs synchronised, outputs registered, no glitches.
`include "bcs_map.svh"
`default_nettype none
module bcs_sequencer #(
    parameter int INTERLOCK_CYC = `BCS_INTERLOCK_CYC, // Interlock delay.
    parameter int START_WAIT_CYC = `BCS_START_WAIT_CYC, // Start delay.
    parameter int NUM_TERM = 7 // Output terminals to route onto.
) (
    input wire logic i_ref_clk, // Reference clock, 50 MHz.
    input wire logic i_reset, // Synchronous reset, active high.
    input wire logic i_run_permit, // Bypass/inverter operation enable.
    input wire logic i_inverter_select, // High inverter, low bypass.
    input wire logic i_forward_run, // Forward run command.
    input wire logic i_reverse_run, // Reverse run command.
    input wire logic i_thermal_ok, // High while motor is normal.
    input wire logic i_status_init, // Operating status initialisation.
    input wire logic i_inverter_fault, // Inverter fault present.
    input wire logic i_fault_is_excluded, // Fault is thermal or processor.
    input wire logic i_fault_bypass_select, // 1 switches to bypass on a fault that is not excluded.
    input wire logic [7:0] i_term_code [NUM_TERM], // Terminal function codes.
    output logic o_input_contactor, // Input contactor coil.
    output logic o_bypass_contactor, // Bypass contactor coil.
    output logic o_output_contactor, // Output contactor coil.
    output logic o_drive_forward, // Inverter drives forward.
    output logic o_drive_reverse, // Inverter drives reverse.
    output logic [NUM_TERM-1:0] o_term // Routed output terminals.
);
    localparam int CW = 32; // Counter width covers any legal delay.

    // Refuse, at elaboration, delays that the counters cannot serve and an empty terminal set.
    if (INTERLOCK_CYC < 1 || START_WAIT_CYC < 1) begin : g_bad_delay
        $error("bcs_sequencer delays must be at least one cycle.");
    end
    if (NUM_TERM < 1) begin : g_bad_term
        $error("bcs_sequencer needs one terminal.");
    end

    logic [7:0] raw_in; // Raw control inputs bundled for syncing.
    logic [7:0] syn; // Synchronised control inputs.

    assign raw_in = {i_fault_bypass_select, i_fault_is_excluded,
                     i_inverter_fault, i_status_init, i_thermal_ok,
                     i_reverse_run, i_forward_run,
                     i_run_permit ^ 1'b0 ? i_inverter_select : 1'b0};

    // Every control input passes through two flops before use.
    bcs_sync #(.WIDTH(8)) u_sync ( // RULE13
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_async(raw_in),
        .o_sync(syn)
    );

    logic permit_q; // Synchronised permit, kept apart from the bundle.
    logic permit_m_q; // First permit stage.
    logic permit_d;
    logic permit_m_d;
    logic sel; // Synchronised inverter select (gated by permit).
    logic fwd;
    logic rev;
    logic therm_ok;
    logic init;
    logic fault;
    logic excl;
    logic fbs;

    assign sel = syn[0];
    assign fwd = syn[1];
    assign rev = syn[2];
    assign therm_ok = syn[3];
    assign init = syn[4];
    assign fault = syn[5];
    assign excl = syn[6];
    assign fbs = syn[7];

    // Separate permit synchroniser.
    always_comb begin
        permit_m_d = i_reset ? 1'b0 : i_run_permit; // RULE13
        permit_d = i_reset ? 1'b0 : permit_m_q;
    end

    always_ff @(posedge i_ref_clk) begin
        permit_m_q <= permit_m_d;
        permit_q <= permit_d;
    end

    // Sequencing state.
    bcs_pkg::bcs_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d; // Delay counter.
    logic tripped_q, tripped_d; // Fault latched; input stays open.
    logic byp_fault_q, byp_fault_d; // Fault switched us to bypass.
    logic mc1_q, mc1_d;
    logic mc2_q, mc2_d;
    logic mc3_q, mc3_d;
    logic fwd_q, fwd_d;
    logic rev_q, rev_d;
    logic [NUM_TERM-1:0] term_q, term_d;

    // Counter reload value, used in several transitions.
    function automatic logic [CW-1:0] load(input int cyc);
        load = CW'(cyc - 1);
    endfunction

    // Next-state and contactor logic. Priority: thermal, fault, init,
    // permit, then select and run handling.
    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
        tripped_d = tripped_q;
        byp_fault_d = byp_fault_q;
        mc1_d = mc1_q;
        mc2_d = mc2_q; // RULE8
        mc3_d = mc3_q;
        fwd_d = 1'b0;
        rev_d = 1'b0;
        if (fault && !tripped_q) begin
            // A fault opens the input and output contactors at once.
            tripped_d = 1'b1; // RULE1
            byp_fault_d = fbs && !excl; // RULE12
            state_d = bcs_pkg::ST_IDLE;
        end
        if (!therm_ok) begin
            // Restart the gap so that a latched fault cannot reclose the
            // bypass side the moment the motor reads normal again.
            cnt_d = load(INTERLOCK_CYC); // RULE10
            mc1_d = 1'b0; // RULE7
            mc2_d = 1'b0; // RULE2
            mc3_d = 1'b0;
            state_d = bcs_pkg::ST_IDLE;
        end else if (tripped_q || (fault && !tripped_q)) begin
            // Input open until reset; bypass as fault selection says.
            mc1_d = 1'b0; // RULE1
            mc3_d = 1'b0; // RULE3
            if (byp_fault_d && mc3_q) begin
                // Interlock gap still applies on the way to bypass.
                mc2_d = 1'b0;
                cnt_d = load(INTERLOCK_CYC); // RULE10
            end else if (byp_fault_d && cnt_q == '0 && !mc3_q) begin
                mc2_d = 1'b1; // RULE2
            end else if (!byp_fault_d) begin
                mc2_d = 1'b0; // RULE12
            end
        end else if (init) begin
            mc2_d = 1'b0; // RULE8
            state_d = bcs_pkg::ST_IDLE;
        end else if (!permit_q) begin
            mc1_d = 1'b1; // RULE4
            mc2_d = 1'b0; // RULE4
            state_d = bcs_pkg::ST_IDLE;
        end else begin
            mc1_d = 1'b1; // RULE1
            case (state_q)
                bcs_pkg::ST_IDLE: begin
                    // Open both sides, then wait out the interlock.
                    mc2_d = 1'b0;
                    mc3_d = 1'b0;
                    cnt_d = load(INTERLOCK_CYC);
                    state_d = sel ? bcs_pkg::ST_GAP_TO_INV
                                  : bcs_pkg::ST_GAP_TO_BYP; // RULE5
                end
                bcs_pkg::ST_GAP_TO_INV: begin
                    if (!sel) begin
                        state_d = bcs_pkg::ST_IDLE;
                    end else if (cnt_q == '0) begin
                        mc3_d = 1'b1; // RULE10
                        cnt_d = load(START_WAIT_CYC);
                        state_d = bcs_pkg::ST_INV_WAIT;
                    end
                end
                bcs_pkg::ST_INV_WAIT: begin
                    if (!sel) begin
                        state_d = bcs_pkg::ST_IDLE;
                    end else if (cnt_q == '0) begin
                        state_d = bcs_pkg::ST_INV_RUN; // RULE11
                    end
                end
                bcs_pkg::ST_INV_RUN: begin
                    if (!sel) begin
                        state_d = bcs_pkg::ST_IDLE;
                    end else begin
                        // Forward wins if both commands are given.
                        fwd_d = fwd; // RULE6
                        rev_d = rev && !fwd; // RULE6
                    end
                end
                bcs_pkg::ST_GAP_TO_BYP: begin
                    if (sel) begin
                        state_d = bcs_pkg::ST_IDLE;
                    end else if (cnt_q == '0) begin
                        mc2_d = 1'b1; // RULE5
                    end
                end
                default: begin
                    state_d = bcs_pkg::ST_IDLE;
                end
            endcase
        end
        // Terminal routing by function code.
        for (int t = 0; t < NUM_TERM; t++) begin
            case (i_term_code[t])
                `BCS_FN_INPUT_MC: term_d[t] = mc1_d; // RULE9
                `BCS_FN_BYPASS_MC: term_d[t] = mc2_d; // RULE9
                `BCS_FN_OUTPUT_MC: term_d[t] = mc3_d; // RULE9
                default: term_d[t] = 1'b0;
            endcase
        end
        if (i_reset) begin
            state_d = bcs_pkg::ST_IDLE;
            cnt_d = '0;
            tripped_d = 1'b0; // RULE1
            byp_fault_d = 1'b0;
            mc1_d = 1'b0;
            mc2_d = 1'b0;
            mc3_d = 1'b0;
            fwd_d = 1'b0;
            rev_d = 1'b0;
            term_d = '0;
        end
    end

    // Register all sequencing state; outputs come straight from here.
    always_ff @(posedge i_ref_clk) begin
        state_q <= state_d;
        cnt_q <= cnt_d;
        tripped_q <= tripped_d;
        byp_fault_q <= byp_fault_d;
        mc1_q <= mc1_d; // RULE13
        mc2_q <= mc2_d;
        mc3_q <= mc3_d;
        fwd_q <= fwd_d;
        rev_q <= rev_d;
        term_q <= term_d;
    end

    assign o_input_contactor = mc1_q;
    assign o_bypass_contactor = mc2_q;
    assign o_output_contactor = mc3_q;
    assign o_drive_forward = fwd_q;
    assign o_drive_reverse = rev_q;
    assign o_term = term_q;
endmodule
`default_nettype wire

// [logic/bcs_sync.sv]
// Purpose: Two-flop synchroniser for a bundle of control inputs.
// Assumes: Inputs may change at any time relative to the clock.
// Notes: The first stage feeds only the second stage.
`default_nettype none
module bcs_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_ref_clk, // Reference clock.
    input wire logic i_reset, // Synchronous reset, active high.
    input wire logic [WIDTH-1:0] i_async, // Raw inputs.
    output logic [WIDTH-1:0] o_sync // Synchronised inputs.
);
    logic [WIDTH-1:0] meta_q; // First stage.
    logic [WIDTH-1:0] meta_d; // First stage next value.
    logic [WIDTH-1:0] sync_q; // Second stage.
    logic [WIDTH-1:0] sync_d; // Second stage next value.

    // Refuse, at elaboration, an empty bundle.
    if (WIDTH < 1) begin : g_bad_width
        $error("bcs_sync needs WIDTH of at least one.");
    end

    // Next values; reset clears both stages.
    always_comb begin
        meta_d = i_reset ? '0 : i_async;
        sync_d = i_reset ? '0 : meta_q;
    end

    // Register both stages.
    always_ff @(posedge i_ref_clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

// [tb/bcs_coil_model.sv]
// Purpose: Bypass and output contactor armatures with drop-out lag.
// Assumes: Coils are driven straight from the sequencer.
// Notes: Flags any moment the line feeds the inverter output.
`default_nettype none
module bcs_coil_model (
    input wire logic i_ref_clk, // Clock.
    input wire logic i_bypass_coil, // Bypass coil.
    input wire logic i_output_coil, // Output coil.
    output logic o_short // Both contacts closed at once.
);
    timeunit 1ns;
    timeprecision 1ps;
    int byp_hold = 0, out_hold = 0; // Cycles before contacts open.
    initial o_short = 1'b0;
    // Contacts open two cycles after the coil drops, as armatures lag.
    always @(posedge i_ref_clk) begin
        byp_hold <= i_bypass_coil ? 2 : (byp_hold > 0 ? byp_hold - 1 : 0);
        out_hold <= i_output_coil ? 2 : (out_hold > 0 ? out_hold - 1 : 0);
        if (byp_hold > 0 && out_hold > 0) o_short <= 1'b1;
    end
endmodule
`default_nettype wire

// [tb/bcs_seq_chk.sv]
// Purpose: Port assertions for the contactor sequencer.
// Assumes: Inputs show at the outputs three edges after they change.
// Notes: The gap bound follows the bound interlock count.
`default_nettype none
module bcs_seq_chk #(
    parameter int INTERLOCK_CYC = 5 // Interlock cycles.
) (
    input wire logic i_ref_clk, // Clock.
    input wire logic i_reset, // Reset.
    input wire logic i_run_permit, // Permit.
    input wire logic i_thermal_ok, // Motor normal.
    input wire logic i_status_init, // Init.
    input wire logic i_inverter_fault, // Fault.
    input wire logic o_input_contactor, // Input coil.
    input wire logic o_bypass_contactor, // Bypass coil.
    input wire logic o_output_contactor, // Output coil.
    input wire logic o_drive_forward, // Drive forward.
    input wire logic o_drive_reverse // Drive reverse.
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap_q, gap_d; // Cycles with bypass and output both open.
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    sequence all_open_s;
        !o_input_contactor && !o_bypass_contactor && !o_output_contactor;
    endsequence
    sequence drive_off_s;
        !o_drive_forward && !o_drive_reverse;
    endsequence
    // The count saturates so that a long idle spell never wraps.
    always_comb begin
        gap_d = (gap_q < 1000) ? gap_q + 1 : gap_q;
        if (o_bypass_contactor || o_output_contactor) gap_d = 0;
    end
    always_ff @(posedge i_ref_clk) begin
        gap_q <= i_reset ? 0 : gap_d;
    end
    thermal_open_a: assert property (!$past(i_thermal_ok, 3) |-> all_open_s)
        else $error("coil closed with motor abnormal");
    fault_open_a: assert property ($past(i_inverter_fault, 3) |->
        !o_input_contactor && !o_output_contactor)
        else $error("coil closed after fault");
    permit_bypass_a: assert property (!$past(i_run_permit, 3) &&
        o_input_contactor |-> !o_bypass_contactor)
        else $error("bypass closed without permit");
    init_bypass_a: assert property ($past(i_status_init, 3) &&
        o_input_contactor |-> !o_bypass_contactor)
        else $error("bypass closed during init");
    coil_excl_a: assert property (!(o_bypass_contactor && o_output_contactor))
        else $error("bypass and output closed together");
    interlock_gap_a: assert property ($rose(o_bypass_contactor) ||
        $rose(o_output_contactor) |-> $past(gap_q) >= INTERLOCK_CYC - 1)
        else $error("interlock gap too short");
    start_wait_a: assert property ($rose(o_output_contactor) |->
        drive_off_s [*2])
        else $error("drive before start wait");
    drive_state_a: assert property (o_drive_forward || o_drive_reverse |->
        !(o_drive_forward && o_drive_reverse) && o_input_contactor &&
        o_output_contactor && !o_bypass_contactor)
        else $error("drive outside inverter run");
endmodule
bind bcs_sequencer bcs_seq_chk #(.INTERLOCK_CYC(INTERLOCK_CYC)) bcs_seq_chk_i (
    .i_ref_clk, .i_reset, .i_run_permit, .i_thermal_ok, .i_status_init,
    .i_inverter_fault, .o_input_contactor, .o_bypass_contactor,
    .o_output_contactor, .o_drive_forward, .o_drive_reverse);
`default_nettype wire

// [tb/test_bypass_contactor_sequencer.sv]
// Purpose: Self-checking bench for the contactor sequencer.
// Assumes: Delays shortened to 5 and 3 cycles.
// Notes: Each check waits until the outputs have settled.
`default_nettype none
module test_bypass_contactor_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_run_permit = 1'b0;
    logic i_inverter_select = 1'b0, i_forward_run = 1'b0;
    logic i_reverse_run = 1'b0, i_thermal_ok = 1'b1, i_status_init = 1'b0;
    logic i_inverter_fault = 1'b0, i_fault_is_excluded = 1'b0;
    logic i_fault_bypass_select = 1'b0, coil_short;
    logic [7:0] i_term_code [7] = '{8'h11, 8'h12, 8'h13, 8'h07, 8'h00,
        8'h13, 8'h11};
    logic o_input_contactor, o_bypass_contactor, o_output_contactor;
    logic o_drive_forward, o_drive_reverse;
    logic [6:0] o_term;
    logic [2:0] exp_q; // Expected input, bypass and output coils.
    wire logic [2:0] mc = {o_input_contactor, o_bypass_contactor,
        o_output_contactor};
    int fail_count = 0, checked = 0, cycles = 0;
    always #10 i_ref_clk = ~i_ref_clk;
    bcs_sequencer #(.INTERLOCK_CYC(5), .START_WAIT_CYC(3)) bcs_sequencer_i (
        .i_ref_clk, .i_reset, .i_run_permit, .i_inverter_select,
        .i_forward_run, .i_reverse_run, .i_thermal_ok, .i_status_init,
        .i_inverter_fault, .i_fault_is_excluded, .i_fault_bypass_select,
        .i_term_code, .o_input_contactor, .o_bypass_contactor,
        .o_output_contactor, .o_drive_forward, .o_drive_reverse, .o_term);
    bcs_coil_model bcs_coil_model_i (.i_ref_clk,
        .i_bypass_coil(o_bypass_contactor),
        .i_output_coil(o_output_contactor), .o_short(coil_short));
    // Steady coils follow thermal, then init, then permit, then select.
    function automatic logic [2:0] exp_mc(input logic [2:0] p);
        if (!i_thermal_ok) return 3'h0;
        if (i_status_init) return {p[2], 1'b0, p[0]};
        if (!i_run_permit) return {1'b1, 1'b0, p[0]};
        return i_inverter_select ? 3'h5 : 3'h6;
    endfunction
    function automatic logic exp_term(input logic [7:0] c);
        return (c == 8'h11) ? exp_q[2] : (c == 8'h12) ? exp_q[1] :
            (c == 8'h13) ? exp_q[0] : 1'b0;
    endfunction
    task automatic conclude;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask
    task automatic check_all(input string nm);
        logic [6:0] t;
        foreach (t[k]) t[k] = exp_term(i_term_code[k]);
        chk(nm, {5'h00, exp_q}, {5'h00, mc});
        chk("term", {1'b0, t}, {1'b0, o_term});
    endtask
    // Fault is cleared with reset so no stale fault survives it.
    task automatic reset_dut;
        @(posedge i_ref_clk);
        i_reset <= 1'b1;
        i_inverter_fault <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        settle(0);
        chk("reset", 8'h00, {5'h00, mc});
    endtask
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hF01AEDCC));
        reset_dut();
        exp_q = 3'h0;
        // Every run code pair; forward wins a tie.
        for (int r = 0; r < 4; r++) begin
            @(posedge i_ref_clk);
            i_run_permit <= 1'b1;
            i_inverter_select <= 1'b1;
            {i_forward_run, i_reverse_run} <= 2'(r);
            settle(20);
            exp_q = exp_mc(exp_q);
            check_all("inverter");
            chk("drive", {6'h00, r[1], r[0] & ~r[1]},
                {6'h00, o_drive_forward, o_drive_reverse});
        end
        @(posedge i_ref_clk);
        i_run_permit <= 1'b0;
        settle(20);
        exp_q = exp_mc(exp_q);
        check_all("no permit");
        @(posedge i_ref_clk);
        i_thermal_ok <= 1'b0;
        settle(20);
        exp_q = exp_mc(exp_q);
        check_all("thermal");
        $display("test basic done");
        // Coast, auto bypass, and an excluded fault; latch held to reset.
        for (int c = 0; c < 3; c++) begin
            reset_dut();
            @(posedge i_ref_clk);
            i_thermal_ok <= 1'b1;
            i_run_permit <= 1'b1;
            i_fault_bypass_select <= (c != 0);
            i_fault_is_excluded <= (c == 2);
            settle(20);
            @(posedge i_ref_clk);
            i_inverter_fault <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            i_inverter_fault <= 1'b0;
            settle(20);
            exp_q = {1'b0, c == 1, 1'b0};
            check_all("fault");
        end
        $display("test fault done");
        reset_dut();
        settle(20);
        exp_q = exp_mc(3'h0);
        check_all("idle");
        // Hand-picked move from inverter to bypass through the gap.
        @(posedge i_ref_clk);
        i_inverter_select <= 1'b0;
        settle(20);
        exp_q = exp_mc(exp_q);
        check_all("bypass");
        for (int n = 0; n < 40; n++) begin
            @(posedge i_ref_clk);
            {i_run_permit, i_inverter_select, i_status_init} <= 3'($urandom);
            i_thermal_ok <= ($urandom % 4) != 0;
            foreach (i_term_code[k]) i_term_code[k] <= 8'h10 + 8'($urandom % 5);
            settle(20);
            exp_q = exp_mc(exp_q);
            check_all("random");
        end
        $display("test random done");
        chk("short", 8'h00, {7'h00, coil_short});
        conclude();
    end
endmodule
`default_nettype wire
